// [dvr_pkg.sv]
package dvr_pkg;
  // Register addresses on the control bus (8-bit offsets)
  localparam logic [7:0] DSP_CONTROL_ADDR     = 8'h46;
  localparam logic [7:0] VOLUME_LEVEL_ADDR    = 8'h4C;
  localparam logic [7:0] RAMP_CONFIG_ADDR     = 8'h4E;
  localparam logic [7:0] EMERG_CONFIG_ADDR    = 8'h4F;
  // Reset values
  localparam logic [7:0] DSP_CONTROL_RST      = 8'h01;
  localparam logic [7:0] VOLUME_LEVEL_RST     = 8'h30;
  localparam logic [7:0] RAMP_CONFIG_RST      = 8'h33;
  localparam logic [7:0] EMERG_CONFIG_RST     = 8'h30;
  // Writable masks (reserved read-only bits read zero)
  localparam logic [7:0] DSP_CONTROL_WMASK    = 8'hF9;
  localparam logic [7:0] EMERG_CONFIG_WMASK   = 8'hFF;
  // Field positions
  localparam int         COEF_SEL_BIT         = 0;
  localparam int         PROC_RATE_LSB        = 3;
  // Volume code landmarks
  localparam logic [7:0] VOLUME_MUTE_CODE     = 8'hFF;
  localparam logic [7:0] VOLUME_UNITY_CODE    = 8'h30;
  // Speed code meaning instant jump
  localparam logic [1:0] RATE_INSTANT         = 2'h3;
  // Speed code for one update every two sample periods
  localparam logic [1:0] RATE_2FS             = 2'h1;
  // Sample periods between updates per speed code
  localparam logic [2:0] PERIOD_1FS           = 3'h1;
  localparam logic [2:0] PERIOD_2FS           = 3'h2;
  localparam logic [2:0] PERIOD_4FS           = 3'h4;
  // Emergency configuration field positions
  localparam int         EMERG_RATE_LSB       = 6;
  localparam int         EMERG_INC_LSB        = 4;
  // Step sizes in code units (one code is 0.5 dB)
  localparam logic [7:0] STEP_4DB             = 8'h08;
  localparam logic [7:0] STEP_2DB             = 8'h04;
  localparam logic [7:0] STEP_1DB             = 8'h02;
  localparam logic [7:0] STEP_HALF_DB         = 8'h01;

  // Ramp configuration fields, bit order as in the register
  typedef struct packed {
    logic [1:0] down_ramp_rate;
    logic [1:0] down_ramp_increment;
    logic [1:0] up_ramp_rate;
    logic [1:0] up_ramp_increment;
  } dvr_ramp_cfg_s;

  // Control bus request
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dvr_bus_req_s;

  // Ramp engine states
  typedef enum logic [1:0] {
    DVR_IDLE,
    DVR_DOWN,
    DVR_UP
  } dvr_state_e;
endpackage : dvr_pkg

// [dvr_volume_ramp.sv]
// Summary of operation
// - Coefficient select 1 picks ROM default set
// - One 8-bit code, both channels, 0.5 dB
// - Code FE is -103 dB, FF mutes
// - Down speed 1/2/4 FS, 11 instant
// - Down step 4/2/1/0.5 dB per update
// - Up speed 1/2/4 FS, 11 instant
// - Up step 4/2/1/0.5 dB per update
// - Emergency ramp down uses separate settings
`timescale 1ns/1ps
module dvr_volume_ramp (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Register access port
  input  wire dvr_pkg::dvr_bus_req_s bus_req,
  output logic [7:0]                 bus_rdata,
  output logic                       bus_rvalid,
  // Audio frame strobe, one cycle per sample period
  input  wire logic                  fs_tick,
  // Clock error or power loss request
  input  wire logic                  emerg_ramp,
  // Applied gain to both channels
  output logic [7:0]                 volume_code,
  output logic                       mute_active,
  output logic                       ramp_busy,
  // Coefficient and rate selection to the processing core
  output logic                       coef_source_select,
  output logic [1:0]                 proc_rate_select
);

  // Registers
  logic [7:0]                 dsp_control_q;      // Coef select and rate
  logic [7:0]                 volume_level_q;     // Programmed target
  dvr_pkg::dvr_ramp_cfg_s     ramp_cfg_q;         // Normal ramp config
  logic [7:0]                 emerg_cfg_q;        // Emergency config
  logic [7:0]                 volume_q;           // Applied code
  logic [2:0]                 fs_cnt_q;           // Sample period counter
  dvr_pkg::dvr_state_e        state_q;            // Ramp direction
  // Combinational helpers
  logic [7:0]                 target;             // Where the gain heads
  logic [1:0]                 rate_sel;           // Active speed
  logic [1:0]                 inc_sel;            // Active step
  logic [7:0]                 step;               // Step in codes
  logic [2:0]                 period;             // FS periods per update
  logic                       update;             // Apply one step now
  logic [8:0]                 sum_up;             // Gain-up result
  logic [8:0]                 sum_dn;             // Gain-down result

  // Register writes from the control bus
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dsp_control_q  <= dvr_pkg::DSP_CONTROL_RST;
      volume_level_q <= dvr_pkg::VOLUME_LEVEL_RST;
      ramp_cfg_q     <= dvr_pkg::RAMP_CONFIG_RST;
      emerg_cfg_q    <= dvr_pkg::EMERG_CONFIG_RST;
    end else if (bus_req.wr_en) begin
      unique case (bus_req.addr)
        dvr_pkg::DSP_CONTROL_ADDR: begin
          dsp_control_q <= bus_req.wdata & dvr_pkg::DSP_CONTROL_WMASK;
        end
        dvr_pkg::VOLUME_LEVEL_ADDR: begin
          volume_level_q <= bus_req.wdata;
        end
        dvr_pkg::RAMP_CONFIG_ADDR: begin
          ramp_cfg_q <= bus_req.wdata;
        end
        dvr_pkg::EMERG_CONFIG_ADDR: begin
          emerg_cfg_q <= bus_req.wdata & dvr_pkg::EMERG_CONFIG_WMASK;
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Register reads, one cycle latency; unmapped reads return zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata  <= 8'h00;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_req.rd_en;
      if (bus_req.rd_en) begin
        unique case (bus_req.addr)
          dvr_pkg::DSP_CONTROL_ADDR:  bus_rdata <= dsp_control_q;
          dvr_pkg::VOLUME_LEVEL_ADDR: bus_rdata <= volume_level_q;
          dvr_pkg::RAMP_CONFIG_ADDR:  bus_rdata <= ramp_cfg_q;
          dvr_pkg::EMERG_CONFIG_ADDR: bus_rdata <= emerg_cfg_q;
          default:                    bus_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Target and active ramp settings
  always_comb begin
    target = emerg_ramp ? dvr_pkg::VOLUME_MUTE_CODE : volume_level_q;
    if (emerg_ramp) begin
      rate_sel = emerg_cfg_q[dvr_pkg::EMERG_RATE_LSB +: 2];
      inc_sel  = emerg_cfg_q[dvr_pkg::EMERG_INC_LSB +: 2];
    end else if (target > volume_q) begin
      rate_sel = ramp_cfg_q.down_ramp_rate;
      inc_sel  = ramp_cfg_q.down_ramp_increment;
    end else begin
      rate_sel = ramp_cfg_q.up_ramp_rate;
      inc_sel  = ramp_cfg_q.up_ramp_increment;
    end
    // Step size in 0.5 dB codes
    unique case (inc_sel)
      2'h0:    step = dvr_pkg::STEP_4DB;
      2'h1:    step = dvr_pkg::STEP_2DB;
      2'h2:    step = dvr_pkg::STEP_1DB;
      default: step = dvr_pkg::STEP_HALF_DB;
    endcase
    // Sample periods between updates
    unique case (rate_sel)
      2'h0:    period = dvr_pkg::PERIOD_1FS;
      2'h1:    period = dvr_pkg::PERIOD_2FS;
      default: period = dvr_pkg::PERIOD_4FS;
    endcase
    update = fs_tick && (fs_cnt_q + 3'h1 >= period);
    sum_up = {1'b0, volume_q} - {1'b0, step};
    sum_dn = {1'b0, volume_q} + {1'b0, step};
  end

  // Sample period counter, restarts after each update or when settled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fs_cnt_q <= 3'h0;
    end else if (target == volume_q || update) begin
      fs_cnt_q <= 3'h0;
    end else if (fs_tick) begin
      fs_cnt_q <= fs_cnt_q + 3'h1;
    end
  end

  // Applied gain ramp engine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      volume_q <= dvr_pkg::VOLUME_UNITY_CODE;
      state_q  <= dvr_pkg::DVR_IDLE;
    end else if (target == volume_q) begin
      // Settled on the target
      state_q <= dvr_pkg::DVR_IDLE;
    end else if (rate_sel == dvr_pkg::RATE_INSTANT) begin
      // Jump straight to the target
      volume_q <= target;
      state_q  <= dvr_pkg::DVR_IDLE;
    end else if (target > volume_q) begin
      state_q <= dvr_pkg::DVR_DOWN;
      if (update) begin
        // Clamp at target, no overshoot
        volume_q <= (sum_dn[8] || sum_dn[7:0] > target) ? target : sum_dn[7:0];
      end
    end else begin
      state_q <= dvr_pkg::DVR_UP;
      if (update) begin
        volume_q <= (sum_up[8] || sum_up[7:0] < target) ? target : sum_up[7:0];
      end
    end
  end

  // Outputs to the processing core
  assign volume_code        = volume_q;
  assign mute_active        = (volume_q == dvr_pkg::VOLUME_MUTE_CODE);
  assign ramp_busy          = (state_q != dvr_pkg::DVR_IDLE);
  assign coef_source_select = dsp_control_q[dvr_pkg::COEF_SEL_BIT];
  assign proc_rate_select   = dsp_control_q[dvr_pkg::PROC_RATE_LSB +: 2];

  // Checks
  // Coefficient select follows the last control write
  AST_COEF_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.wr_en && bus_req.addr == dvr_pkg::DSP_CONTROL_ADDR
      |=> coef_source_select == $past(bus_req.wdata[dvr_pkg::COEF_SEL_BIT]))
    else $error("coef select not taken from write");
  // Programming the mute code with an instant down ramp mutes next cycle
  AST_MUTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !emerg_ramp && volume_level_q == dvr_pkg::VOLUME_MUTE_CODE && volume_q != dvr_pkg::VOLUME_MUTE_CODE
      && ramp_cfg_q.down_ramp_rate == dvr_pkg::RATE_INSTANT |=> mute_active)
    else $error("mute code not reached");
  // Instant down jumps to the target
  AST_DOWN_INSTANT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !emerg_ramp && volume_level_q > volume_q && ramp_cfg_q.down_ramp_rate == dvr_pkg::RATE_INSTANT
      |=> volume_q == $past(volume_level_q))
    else $error("instant down not applied");
  // Instant up restores the target
  AST_UP_INSTANT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !emerg_ramp && volume_level_q < volume_q && ramp_cfg_q.up_ramp_rate == dvr_pkg::RATE_INSTANT
      |=> volume_q == $past(volume_level_q))
    else $error("instant up not applied");
  // Gain only moves on a frame strobe unless instant
  AST_NO_TICK_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fs_tick && rate_sel != dvr_pkg::RATE_INSTANT |=> $stable(volume_q))
    else $error("gain moved without frame tick");
  // Down update lowers gain by at most one step
  AST_DOWN_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    update && !emerg_ramp && target > volume_q && rate_sel != dvr_pkg::RATE_INSTANT
      |=> volume_q - $past(volume_q) <= $past(step) && volume_q > $past(volume_q))
    else $error("down step wrong");
  // Up update raises gain by at most one step
  AST_UP_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    update && !emerg_ramp && target < volume_q && rate_sel != dvr_pkg::RATE_INSTANT
      |=> $past(volume_q) - volume_q <= $past(step) && volume_q < $past(volume_q))
    else $error("up step wrong");
  // Down update never passes the target
  AST_NO_OVERSHOOT_DN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    update && target > volume_q && rate_sel != dvr_pkg::RATE_INSTANT |=> volume_q <= $past(target))
    else $error("down ramp passed target");
  // Up update never passes the target
  AST_NO_OVERSHOOT_UP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    update && target < volume_q && rate_sel != dvr_pkg::RATE_INSTANT |=> volume_q >= $past(target))
    else $error("up ramp passed target");
  // Busy drops once the applied code sits on the target
  AST_SETTLED_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    target == volume_q |=> !ramp_busy)
    else $error("busy while settled");
  // Emergency ramp only ever lowers the gain
  AST_EMERG_DIR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emerg_ramp && $past(emerg_ramp) |-> volume_q >= $past(volume_q))
    else $error("emergency ramp raised gain");
  // Two-period speed skips the first strobe
  AST_RATE2: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fs_tick && fs_cnt_q == 3'h0 && rate_sel == dvr_pkg::RATE_2FS |=> $stable(volume_q))
    else $error("half rate updated too early");
  // Main scenarios reached
  COV_RAMP_DOWN: cover property (@(posedge clk_sys) state_q == dvr_pkg::DVR_DOWN ##[1:200] state_q == dvr_pkg::DVR_IDLE);
  COV_RAMP_UP: cover property (@(posedge clk_sys) state_q == dvr_pkg::DVR_UP ##[1:200] state_q == dvr_pkg::DVR_IDLE);
  COV_MUTE: cover property (@(posedge clk_sys) mute_active && emerg_ramp);
  COV_CLAMP: cover property (@(posedge clk_sys) update && target > volume_q && sum_dn[7:0] > target);

endmodule : dvr_volume_ramp

// [tb_dvr_volume_ramp.sv]
`timescale 1ns/1ps
module tb_dvr_volume_ramp;
  // Table row: optional write, then a read of the same address
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } dvr_row_s;
  // Stimulus and observed signals
  logic                  clk_sys = 1'b0;
  logic                  rst_n   = 1'b0;
  dvr_pkg::dvr_bus_req_s bus_req = '0;
  logic                  fs_tick = 1'b0;
  logic                  emerg_ramp = 1'b0;
  logic [7:0]            bus_rdata, volume_code;
  logic                  bus_rvalid, mute_active, ramp_busy, coef_source_select;
  logic [1:0]            proc_rate_select;
  int                    n_errors = 0;
  int                    num_checks = 0;
  int                    cycles = 0;
  logic [7:0]            rd;
  dvr_row_s              rows [10] = '{
    {1'b0, 8'h46, 8'h00, 8'h01}, {1'b0, 8'h4C, 8'h00, 8'h30}, {1'b0, 8'h4E, 8'h00, 8'h33},
    {1'b0, 8'h4F, 8'h00, 8'h30}, {1'b0, 8'h10, 8'h00, 8'h00}, {1'b1, 8'h10, 8'hAA, 8'h00},
    {1'b1, 8'h46, 8'hFF, 8'hF9}, {1'b1, 8'h46, 8'h01, 8'h01}, {1'b1, 8'h4E, 8'h5A, 8'h5A},
    {1'b1, 8'h4E, 8'h33, 8'h33}};
  // Clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  // Device under test
  dvr_volume_ramp uut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .fs_tick(fs_tick), .emerg_ramp(emerg_ramp), .volume_code(volume_code),
    .mute_active(mute_active), .ramp_busy(ramp_busy), .coef_source_select(coef_source_select),
    .proc_rate_select(proc_rate_select));
  // Compare and report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys) bus_req <= '0;
    @(negedge clk_sys);
  endtask : wr
  // One-cycle read, answer sampled one cycle later
  task automatic rdreg(input logic [7:0] a, output logic [7:0] d);
    bus_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys) bus_req <= '0;
    chk("rvalid", 8'h01, {7'h00, bus_rvalid});
    d = bus_rdata;
    @(negedge clk_sys);
    chk("rvalid end", 8'h00, {7'h00, bus_rvalid});
  endtask : rdreg
  // One sample-period strobe
  task automatic tick;
    fs_tick <= 1'b1;
    @(negedge clk_sys) fs_tick <= 1'b0;
    @(negedge clk_sys);
  endtask : tick
  // New target, count strobes until the applied code lands on it
  task automatic ramp(input logic [7:0] tgt, input int exp_n);
    int n;
    n = 0;
    wr(8'h4C, tgt);
    @(negedge clk_sys);
    chk("busy", 8'h01, {7'h00, ramp_busy});
    while (volume_code !== tgt && n < 40) begin
      tick();
      n++;
    end
    chk("ticks", exp_n[7:0], n[7:0]);
    chk("busy end", 8'h00, {7'h00, ramp_busy});
    $display("ramp to %h done", tgt);
  endtask : ramp
  // Main sequence
  initial begin
    repeat (12) @(negedge clk_sys);
    chk("rst vol", 8'h30, volume_code);
    chk("rst coef", 8'h01, {7'h00, coef_source_select});
    rst_n = 1'b1;
    // Register table rows
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].data);
      rdreg(rows[i].addr, rd);
      chk("reg", rows[i].exp, rd);
    end
    $display("register table done");
    // Coefficient source and rate fields
    wr(8'h46, 8'h18);
    chk("coef0", 8'h00, {7'h00, coef_source_select});
    chk("rate", 8'h03, {6'h00, proc_rate_select});
    wr(8'h46, 8'h01);
    chk("coef1", 8'h01, {7'h00, coef_source_select});
    $display("coefficient select done");
    // Down ramps: 1 FS half dB, then 2 FS 4 dB with clamped last step
    ramp(8'h34, 4);
    wr(8'h4E, 8'h43);
    ramp(8'h48, 6);
    // Up ramp: 4 FS, 2 dB
    wr(8'h4E, 8'h39);
    ramp(8'h40, 8);
    // Down 4 FS 2 dB, then up 2 FS 1 dB
    wr(8'h4E, 8'h96);
    ramp(8'h44, 4);
    ramp(8'h40, 4);
    // Instant up, then instant down to mute
    wr(8'h4E, 8'hFF);
    wr(8'h4C, 8'h00);
    repeat (3) @(negedge clk_sys);
    chk("inst up", 8'h00, volume_code);
    wr(8'h4C, 8'hFF);
    repeat (3) @(negedge clk_sys);
    chk("inst dn", 8'hFF, volume_code);
    chk("mute", 8'h01, {7'h00, mute_active});
    $display("instant ramps done");
    // Emergency ramp keeps its own slow setting while normal down is instant
    wr(8'h4E, 8'hF3);
    ramp(8'hFD, 2);
    emerg_ramp <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("emg hold", 8'hFD, volume_code);
    tick();
    chk("emg 1", 8'hFE, volume_code);
    chk("not mute", 8'h00, {7'h00, mute_active});
    tick();
    chk("emg 2", 8'hFF, volume_code);
    emerg_ramp <= 1'b0;
    tick();
    chk("back", 8'hFE, volume_code);
    $display("emergency done");
    // Second reset mid-run
    rst_n = 1'b0;
    @(negedge clk_sys);
    chk("rst2 vol", 8'h30, volume_code);
    rst_n = 1'b1;
    rdreg(8'h4E, rd);
    chk("rst2 cfg", 8'h33, rd);
    $display("reset done");
    wrap_up();
  end
endmodule : tb_dvr_volume_ramp
